// File: verilog/surh_cfg.svh
// surh_cfg.svh: opcodes, status and message codes, sense keys, lengths and bus timing.
// assumes: included by bare name; definitions only.
`ifndef SURH_CFG_SVH
`define SURH_CFG_SVH

// operation codes
`define SURH_OP_RESERVE   8'h16
`define SURH_OP_RELEASE   8'h17
`define SURH_OP_INQUIRY   8'h12
`define SURH_OP_REQSENSE  8'h03

// status bytes (status key sits in bits 5:1)
`define SURH_ST_GOOD      8'h00
`define SURH_ST_CHECK     8'h02
`define SURH_ST_CONFLICT  8'h18

// messages
`define SURH_MSG_COMPLETE 8'h00
`define SURH_MSG_BDR      8'h0C
`define SURH_MSG_IDENT    7

// sense keys and sense layout
`define SURH_KEY_NONE     4'h0
`define SURH_KEY_ILLEGAL  4'h5
`define SURH_KEY_UNITATT  4'h6
`define SURH_SENSE_CODE   8'h70
`define SURH_SENSE_ADDLEN 8'h0A
`define SURH_SENSE_LEN    7'h12

// command block layout
`define SURH_CDB_LAST     7'h05
`define SURH_TP_BIT       4
`define SURH_INQ_LEN      7'h60

// timing
`define SURH_CLK_NS       10
`define SURH_SETTLE_NS    400
`define SURH_DESKEW_NS    55
`define SURH_SETTLE_CYC   ((`SURH_SETTLE_NS + `SURH_CLK_NS - 1) / `SURH_CLK_NS)
`define SURH_DESKEW_CYC   ((`SURH_DESKEW_NS + `SURH_CLK_NS - 1) / `SURH_CLK_NS)

`endif

// File: verilog/surh_pkg.sv
// surh_pkg.sv: pin bundles and state types of the reservation handler.
// assumes: bus levels are true-asserted; the transceiver inverts.
package surh_pkg;

  typedef struct packed {
    logic       sel;
    logic       atn;
    logic       ack;
    logic       rst;
    logic [7:0] db;
    logic [2:0] own_id;
  } surh_pins_type;

  typedef struct packed {
    logic       bsy_oe_n;
    logic       req_oe_n;
    logic       cd_oe_n;
    logic       io_oe_n;
    logic       msg_oe_n;
    logic       db_oe_n;
    logic [7:0] db_o;
  } surh_drv_type;

  typedef enum logic [7:0] {
    ST_FREE = 8'h01,
    ST_SELW = 8'h02,
    ST_MOUT = 8'h04,
    ST_CMD  = 8'h08,
    ST_EXEC = 8'h10,
    ST_DIN  = 8'h20,
    ST_STAT = 8'h40,
    ST_MIN  = 8'h80
  } surh_state_type;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_SETUP = 4'h2,
    HS_REQ   = 4'h4,
    HS_ACKOF = 4'h8
  } surh_hs_type;

endpackage

// File: verilog/surh_handshake.sv
// surh_handshake.sv: one asynchronous req/ack byte transfer, either direction.
// assumes: ack and db are already synchronised; start only while idle.
`timescale 1ns/1ns
`include "surh_cfg.svh"
module surh_handshake (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // request from the sequencer
  input  wire logic        start,
  input  wire logic        to_init,
  input  wire logic        settle,
  input  wire logic        abort,
  input  wire logic [7:0]  tx_byte,
  // synchronised bus inputs
  input  wire logic        ack,
  input  wire logic [7:0]  db_in,
  // results
  output logic             req,
  output logic             done,
  output logic [7:0]       rx_byte,
  output logic [7:0]       db_o
);
  import surh_pkg::*;

  surh_hs_type st_ff;
  surh_hs_type nxt_st;
  logic [5:0]  dly_ff;
  logic [5:0]  nxt_dly;
  logic        req_ff;
  logic [7:0]  rx_ff;
  logic [7:0]  txd_ff;

  // first byte of a phase waits a bus settle delay, later bytes only a deskew
  assign nxt_dly = (st_ff == HS_IDLE) ? (settle ? 6'(`SURH_SETTLE_CYC) : 6'(`SURH_DESKEW_CYC))
                 : (dly_ff != 6'h00) ? dly_ff - 6'h01 : dly_ff;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      HS_IDLE:  if (start) nxt_st = HS_SETUP;
      HS_SETUP: if (dly_ff == 6'h01) nxt_st = HS_REQ;
      HS_REQ:   if (ack) nxt_st = HS_ACKOF;
      HS_ACKOF: if (!ack) nxt_st = HS_IDLE;
      default:  nxt_st = HS_IDLE;
    endcase
    if (abort) nxt_st = HS_IDLE;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff  <= HS_IDLE;
      dly_ff <= 6'h00;
      req_ff <= 1'b0;
      rx_ff  <= 8'h00;
      txd_ff <= 8'h00;
    end else begin
      st_ff  <= nxt_st;
      dly_ff <= nxt_dly;
      req_ff <= (nxt_st == HS_REQ);
      if (st_ff == HS_REQ && ack && !to_init) rx_ff <= db_in;
      if (st_ff == HS_IDLE && start) txd_ff <= tx_byte;
    end
  end

  assign req     = req_ff;
  assign done    = (st_ff == HS_ACKOF) && !ack && !abort;
  assign rx_byte = rx_ff;
  assign db_o    = txd_ff;
endmodule

// File: verilog/surh_top.sv
// surh_top.sv: target-side sequencer for reserve, release and inquiry with reservation tracking.
// assumes: bus pins are true-asserted levels through an external transceiver; one target id.
// Function
// - reserve: select, identify, command block; then good status, complete, bus free.
// - accepted reserve records the issuer as holder; others are denied.
// - holder may reserve again without error; new reservation replaces old.
// - release from the holder clears the reservation.
// - bus device reset message from any initiator clears the reservation.
// - bus reset condition clears the reservation.
// - after message or bus reset, next command gets unit attention key 6.
// - foreign holder: all but release, inquiry, request sense get reservation conflict.
// - third-party bit set on reserve or release gives check, illegal request.
// - third-party device id field is ignored.
// - release from non-holder keeps the reservation and answers good.
// - release: command block, good status, command complete, then bus free.
// - inquiry: data-in with inquiry data, good status, complete, bus free.
// - opcode 16 reserve, 17 release, 12 inquiry.
// - nonzero control byte gives check condition, illegal request.
`timescale 1ns/1ns
`include "surh_cfg.svh"
module surh_top (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  // bus pins
  input  wire surh_pkg::surh_pins_type pins,
  output surh_pkg::surh_drv_type       drv,
  // inquiry data source
  output logic [6:0]                  inq_idx,
  input  wire logic [7:0]             inq_byte,
  // commands handed on to the rest of the unit
  output logic                        cmd_strobe,
  output logic [7:0]                  cmd_code,
  // reservation state
  output logic                        resv_valid,
  output logic [2:0]                  resv_owner,
  output logic                        ua_pending
);
  import surh_pkg::*;

  function automatic logic [3:0] find_other(input logic [7:0] b);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (b[i]) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  function automatic logic [6:0] clip_len(input logic [7:0] alloc, input logic [6:0] lim);
    return (alloc > {1'b0, lim}) ? lim : alloc[6:0];
  endfunction

  function automatic logic [7:0] sense_byte(input logic [6:0] idx, input logic [3:0] key);
    case (idx)
      7'h00:   return `SURH_SENSE_CODE;
      7'h02:   return {4'h0, key};
      7'h07:   return `SURH_SENSE_ADDLEN;
      default: return 8'h00;
    endcase
  endfunction

  // three-stage input synchroniser; a bit moves once stages two and three agree
  surh_pins_type s1_ff, s2_ff, s3_ff, cl_ff;
  surh_pins_type nxt_cl;
  assign nxt_cl = surh_pins_type'((s2_ff & ~(s2_ff ^ s3_ff)) | (cl_ff & (s2_ff ^ s3_ff)));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      cl_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      cl_ff <= nxt_cl;
    end
  end

  surh_state_type state_ff, nxt_state;
  logic [2:0]  init_ff, lun_ff, owner_ff;
  logic [7:0]  cdb_ff [0:5];
  logic [6:0]  cnt_ff, nxt_cnt, len_ff;
  logic        wait_ff, resv_ff, ua_ff, strobe_ff;
  logic [7:0]  status_ff, code_ff;
  logic [3:0]  sense_ff;
  logic        bsy_ff, cd_ff, io_ff, msg_ff, dbo_ff;

  // selection
  logic [7:0]  own_bit;
  logic [3:0]  other;
  logic        sel_hit, rst_ev;
  assign own_bit = 8'h01 << cl_ff.own_id;
  assign other   = find_other(cl_ff.db & ~own_bit);
  assign rst_ev  = cl_ff.rst;
  assign sel_hit = (state_ff == ST_FREE) && cl_ff.sel && |(cl_ff.db & own_bit) && other[3]
                   && !rst_ev;

  // byte transfer engine
  logic        xfer, to_init, hs_start, hs_done, hs_req;
  logic [7:0]  hs_rx, hs_db, tx_byte;
  assign xfer     = state_ff inside {ST_MOUT, ST_CMD, ST_DIN, ST_STAT, ST_MIN};
  assign to_init  = state_ff inside {ST_DIN, ST_STAT, ST_MIN};
  assign hs_start = xfer && !wait_ff && !rst_ev;
  assign tx_byte  = (state_ff == ST_STAT) ? status_ff
                  : (state_ff == ST_MIN) ? `SURH_MSG_COMPLETE
                  : (cdb_ff[0] == `SURH_OP_INQUIRY) ? inq_byte
                  : sense_byte(cnt_ff, sense_ff);

  surh_handshake u_hs (
    .mclk    (mclk),
    .rstn    (rstn),
    .start   (hs_start),
    .to_init (to_init),
    .settle  (cnt_ff == 7'h00),
    .abort   (rst_ev),
    .tx_byte (tx_byte),
    .ack     (cl_ff.ack),
    .db_in   (cl_ff.db),
    .req     (hs_req),
    .done    (hs_done),
    .rx_byte (hs_rx),
    .db_o    (hs_db)
  );

  // command decode; the third-party id bits of byte 1 are never looked at
  logic [7:0]  op;
  logic        is_rsv, is_rel, is_inq, is_rs, own_match, fmt_bad, tp_bad, conflict;
  logic        rj_ua, rj_fmt, rj_cfl, rj_tp, exec_ev, exec_good, bdr_ev;
  logic [6:0]  xlen;
  assign op        = cdb_ff[0];
  assign is_rsv    = (op == `SURH_OP_RESERVE);
  assign is_rel    = (op == `SURH_OP_RELEASE);
  assign is_inq    = (op == `SURH_OP_INQUIRY);
  assign is_rs     = (op == `SURH_OP_REQSENSE);
  assign own_match = (owner_ff == init_ff);
  assign fmt_bad   = (cdb_ff[5] != 8'h00) || (lun_ff != 3'h0);
  assign tp_bad    = (is_rsv || is_rel) && cdb_ff[1][`SURH_TP_BIT];
  assign conflict  = resv_ff && !own_match && !(is_rel || is_inq || is_rs);
  // unit attention outranks format errors, which outrank conflicts
  assign rj_ua     = ua_ff && !is_rs;
  assign rj_fmt    = !rj_ua && fmt_bad;
  assign rj_cfl    = !rj_ua && !fmt_bad && conflict;
  assign rj_tp     = !rj_ua && !fmt_bad && !conflict && tp_bad;
  assign exec_ev   = (state_ff == ST_EXEC) && !rst_ev;
  assign exec_good = !(rj_ua || rj_fmt || rj_cfl || rj_tp);
  assign bdr_ev    = (state_ff == ST_MOUT) && hs_done && (hs_rx == `SURH_MSG_BDR);
  assign xlen      = is_inq ? clip_len(cdb_ff[4], `SURH_INQ_LEN)
                   : is_rs ? clip_len(cdb_ff[4], `SURH_SENSE_LEN) : 7'h00;

  // reservation and attention; a reset event wins over any command in the same cycle
  logic        nxt_resv, nxt_ua;
  logic [7:0]  nxt_status;
  logic [3:0]  nxt_sense;
  assign nxt_resv = (rst_ev || bdr_ev) ? 1'b0
                  : (exec_ev && exec_good && is_rsv) ? 1'b1
                  : (exec_ev && exec_good && is_rel && own_match) ? 1'b0
                  : resv_ff;
  assign nxt_ua   = (rst_ev || bdr_ev) ? 1'b1
                  : (exec_ev && (rj_ua || (is_rs && exec_good))) ? 1'b0 : ua_ff;
  assign nxt_status = rj_cfl ? `SURH_ST_CONFLICT
                    : (rj_ua || rj_fmt || rj_tp) ? `SURH_ST_CHECK
                    : `SURH_ST_GOOD;
  assign nxt_sense  = rj_ua ? `SURH_KEY_UNITATT
                    : (rj_fmt || rj_tp) ? `SURH_KEY_ILLEGAL
                    : (is_rs && ua_ff) ? `SURH_KEY_UNITATT
                    : is_rs ? sense_ff : `SURH_KEY_NONE;

  // phase sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_FREE: if (sel_hit) nxt_state = ST_SELW;
      ST_SELW: if (!cl_ff.sel) nxt_state = cl_ff.atn ? ST_MOUT : ST_CMD;
      ST_MOUT: begin
        if (bdr_ev) nxt_state = ST_FREE;
        else if (hs_done && !cl_ff.atn) nxt_state = ST_CMD;
      end
      ST_CMD:  if (hs_done && cnt_ff == `SURH_CDB_LAST) nxt_state = ST_EXEC;
      ST_EXEC: nxt_state = (exec_good && xlen != 7'h00) ? ST_DIN : ST_STAT;
      ST_DIN:  if (hs_done && cnt_ff == len_ff - 7'h01) nxt_state = ST_STAT;
      ST_STAT: if (hs_done) nxt_state = ST_MIN;
      ST_MIN:  if (hs_done) nxt_state = ST_FREE;
      default: nxt_state = ST_FREE;
    endcase
    if (rst_ev) nxt_state = ST_FREE;
  end

  assign nxt_cnt = (nxt_state != state_ff) ? 7'h00 : hs_done ? cnt_ff + 7'h01 : cnt_ff;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_FREE;
      cnt_ff   <= 7'h00;
      wait_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      wait_ff  <= !rst_ev && (hs_start || (wait_ff && !hs_done));
    end
  end

  // initiator id is taken at selection, the identify message sets the unit number
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      init_ff <= 3'h0;
      lun_ff  <= 3'h0;
    end else begin
      if (sel_hit) init_ff <= other[2:0];
      if (sel_hit) lun_ff <= 3'h0;
      else if (state_ff == ST_MOUT && hs_done && hs_rx[`SURH_MSG_IDENT]) lun_ff <= hs_rx[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 6; i++) cdb_ff[i] <= 8'h00;
    end else if (state_ff == ST_CMD && hs_done) begin
      cdb_ff[cnt_ff[2:0]] <= hs_rx;
    end
  end

  // power-up counts as a hardware reset, so attention starts pending
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      resv_ff  <= 1'b0;
      ua_ff    <= 1'b1;
      owner_ff <= 3'h0;
    end else begin
      resv_ff <= nxt_resv;
      ua_ff   <= nxt_ua;
      if (exec_ev && exec_good && is_rsv) owner_ff <= init_ff;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= `SURH_ST_GOOD;
      sense_ff  <= `SURH_KEY_NONE;
      len_ff    <= 7'h00;
      strobe_ff <= 1'b0;
      code_ff   <= 8'h00;
    end else begin
      strobe_ff <= exec_ev && exec_good && !(is_rsv || is_rel || is_inq || is_rs);
      if (exec_ev) begin
        status_ff <= nxt_status;
        sense_ff  <= nxt_sense;
        len_ff    <= xlen;
        code_ff   <= op;
      end else if (state_ff == ST_MIN && hs_done && is_rs) begin
        sense_ff  <= `SURH_KEY_NONE;
      end
    end
  end

  // bus control lines follow the next phase so they settle before the first req
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bsy_ff <= 1'b0;
      cd_ff  <= 1'b0;
      io_ff  <= 1'b0;
      msg_ff <= 1'b0;
      dbo_ff <= 1'b0;
    end else begin
      bsy_ff <= (nxt_state != ST_FREE);
      cd_ff  <= nxt_state inside {ST_MOUT, ST_CMD, ST_STAT, ST_MIN};
      io_ff  <= nxt_state inside {ST_DIN, ST_STAT, ST_MIN};
      msg_ff <= nxt_state inside {ST_MOUT, ST_MIN};
      dbo_ff <= nxt_state inside {ST_DIN, ST_STAT, ST_MIN};
    end
  end

  assign drv = '{bsy_oe_n: ~bsy_ff, req_oe_n: ~hs_req, cd_oe_n: ~cd_ff, io_oe_n: ~io_ff,
                 msg_oe_n: ~msg_ff, db_oe_n: ~dbo_ff, db_o: hs_db};
  assign inq_idx    = cnt_ff;
  assign cmd_strobe = strobe_ff;
  assign cmd_code   = code_ff;
  assign resv_valid = resv_ff;
  assign resv_owner = owner_ff;
  assign ua_pending = ua_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_reserve_records: assert property (
    exec_ev && exec_good && is_rsv |=> resv_ff && owner_ff == $past(init_ff))
    else $error("reserve did not record holder");
  a_rereserve_good: assert property (
    exec_ev && resv_ff && own_match && is_rsv && !ua_ff && !fmt_bad && !tp_bad
    |=> status_ff == `SURH_ST_GOOD && resv_ff)
    else $error("holder reserve not accepted");
  a_release_clears: assert property (
    exec_ev && exec_good && is_rel && resv_ff && own_match |=> !resv_ff)
    else $error("holder release kept reservation");
  a_release_foreign: assert property (
    exec_ev && is_rel && resv_ff && !own_match && !ua_ff && !fmt_bad && !tp_bad
    |=> resv_ff && status_ff == `SURH_ST_GOOD)
    else $error("foreign release disturbed reservation");
  a_bdr_clears: assert property (
    bdr_ev |=> !resv_ff && ua_ff ##1 state_ff == ST_FREE)
    else $error("device reset message did not clear");
  a_busrst_clears: assert property (
    rst_ev |=> !resv_ff && ua_ff && state_ff == ST_FREE)
    else $error("bus reset did not clear");
  a_ua_report: assert property (
    exec_ev && ua_ff && !is_rs |=> status_ff == `SURH_ST_CHECK
                                  && sense_ff == `SURH_KEY_UNITATT && !ua_ff)
    else $error("unit attention not reported");
  a_conflict_stat: assert property (
    exec_ev && !ua_ff && !fmt_bad && resv_ff && owner_ff != init_ff
    && op != `SURH_OP_RELEASE && op != `SURH_OP_INQUIRY && op != `SURH_OP_REQSENSE
    |=> status_ff == `SURH_ST_CONFLICT)
    else $error("missing reservation conflict");
  a_tp_reject: assert property (
    exec_ev && !ua_ff && cdb_ff[5] == 8'h00 && lun_ff == 3'h0 && !conflict
    && (op == `SURH_OP_RESERVE || op == `SURH_OP_RELEASE) && cdb_ff[1][`SURH_TP_BIT]
    |=> status_ff == `SURH_ST_CHECK && sense_ff == `SURH_KEY_ILLEGAL)
    else $error("third party not rejected");
  a_ctl_reject: assert property (
    exec_ev && !rj_ua && cdb_ff[5] != 8'h00
    |=> status_ff == `SURH_ST_CHECK && sense_ff == `SURH_KEY_ILLEGAL)
    else $error("control byte not rejected");
  a_status_complete: assert property (
    state_ff == ST_STAT && hs_done && !rst_ev |=> state_ff == ST_MIN ##1 bsy_ff)
    else $error("status not followed by message in");
  a_inq_datain: assert property (
    exec_ev && exec_good && is_inq && xlen != 7'h00 |=> state_ff == ST_DIN ##1 io_ff)
    else $error("inquiry skipped data in");
  a_bus_free: assert property (
    state_ff == ST_MIN && hs_done && !rst_ev |=> ##1 !bsy_ff && !cd_ff)
    else $error("busy not released");

  c_reserve_ok: cover property (exec_ev && exec_good && is_rsv);
  c_conflict: cover property (exec_ev && rj_cfl);
  c_bdr: cover property (bdr_ev && resv_ff);
  c_inquiry: cover property (state_ff == ST_DIN && hs_done);
endmodule

// File: testbench/surh_init_model.sv
// surh_init_model.sv: behavioural initiator driving the target's bus pins.
// assumes: true-asserted levels; terminated bus reads 0 wherever nobody drives.
`timescale 1ns/1ns
module surh_init_model #(
  parameter logic [2:0] TGT_ID = 3'h5
) (
  input  wire logic                   mclk,
  input  wire surh_pkg::surh_drv_type drv,
  output surh_pkg::surh_pins_type     pins
);
  import surh_pkg::*;
  logic [7:0] din_q[$];
  logic [7:0] stat_b;
  logic [7:0] msg_b;
  int         hangs;

  initial begin
    pins = '0;
    pins.own_id = TGT_ID;
    hangs = 0;
  end

  // one whole connection: selection, one message byte, then whatever the target asks for
  task automatic run(input logic [2:0] iid, input logic [7:0] msg, input logic [47:0] cdb);
    int n;
    int k;
    logic [7:0] rd;
    din_q.delete();
    stat_b = 8'hFF;
    msg_b = 8'hFF;
    k = 0;
    @(posedge mclk);
    pins.db <= (8'h01 << TGT_ID) | (8'h01 << iid);
    pins.atn <= 1'b1;
    pins.sel <= 1'b1;
    for (n = 0; n < 100 && drv.bsy_oe_n; n++) @(negedge mclk);
    if (n == 100) hangs++;
    @(posedge mclk);
    pins.sel <= 1'b0;
    pins.db <= 8'h00;
    while (!drv.bsy_oe_n && hangs == 0) begin
      for (n = 0; n < 300 && drv.req_oe_n && !drv.bsy_oe_n; n++) @(negedge mclk);
      if (n == 300) hangs++;
      else if (!drv.req_oe_n) begin
        @(posedge mclk);
        if (drv.io_oe_n) begin
          // atn drops before the only message byte is acknowledged
          if (drv.msg_oe_n) pins.db <= cdb[47-8*k -: 8];
          else pins.db <= msg;
          if (drv.msg_oe_n) k++;
          else pins.atn <= 1'b0;
        end else begin
          // terminated bus reads 0 wherever the target does not drive it
          rd = drv.db_oe_n ? 8'h00 : drv.db_o;
          if (drv.cd_oe_n) din_q.push_back(rd);
          else if (drv.msg_oe_n) stat_b = rd;
          else msg_b = rd;
        end
        // deskew plus cable skew before acknowledging
        repeat (6) @(posedge mclk);
        pins.ack <= 1'b1;
        for (n = 0; n < 300 && !drv.req_oe_n; n++) @(negedge mclk);
        if (n == 300) hangs++;
        @(posedge mclk);
        pins.ack <= 1'b0;
        pins.db <= 8'h00;
        @(negedge mclk);
      end
    end
  endtask

  task automatic bus_reset();
    @(posedge mclk);
    pins.rst <= 1'b1;
    repeat (12) @(posedge mclk);
    pins.rst <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask
endmodule

// File: testbench/tb.sv
// tb.sv: self-checking bench for the reservation handler with one initiator model.
// assumes: the model answers every handshake; inquiry bytes follow a fixed pattern.
`timescale 1ns/1ns
`include "surh_cfg.svh"
module tb;
  import surh_pkg::*;
  localparam logic [47:0] RSV = {`SURH_OP_RESERVE, 40'h0};
  localparam logic [47:0] REL = {`SURH_OP_RELEASE, 40'h0};
  localparam logic [47:0] TUR = 48'h0;
  localparam logic [47:0] INQ = {`SURH_OP_INQUIRY, 24'h0, 8'h04, 8'h00};
  logic          mclk;
  logic          rstn;
  surh_pins_type pins;
  surh_drv_type  drv;
  logic [6:0]    inq_idx;
  logic [7:0]    inq_byte;
  logic          resv_valid;
  logic [2:0]    resv_owner;
  logic          ua_pending;
  logic          cmd_strobe;
  logic [7:0]    cmd_code;
  int            strobes;
  int            fail_count;
  int            compares;

  // pattern lets each returned byte be traced back to its index
  assign inq_byte = {1'b1, inq_idx} ^ 8'h5A;

  surh_top DUT (.mclk(mclk), .rstn(rstn), .pins(pins), .drv(drv), .inq_idx(inq_idx),
    .inq_byte(inq_byte), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .resv_valid(resv_valid), .resv_owner(resv_owner), .ua_pending(ua_pending));
  surh_init_model u_init (.mclk(mclk), .drv(drv), .pins(pins));

  // the strobe stands one cycle only, so it is counted rather than sampled late
  always @(posedge mclk) begin
    if (rstn && cmd_strobe) strobes <= strobes + 1;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [2:0] iid, input logic [47:0] cdb, input logic [7:0] st);
    u_init.run(iid, 8'h80, cdb);
    chk("status", st, u_init.stat_b);
    chk("message in", `SURH_MSG_COMPLETE, u_init.msg_b);
  endtask

  task automatic resv_is(input logic v, input logic [2:0] own);
    chk("resv_valid", {7'h0, v}, {7'h0, resv_valid});
    if (v) chk("resv_owner", {5'h0, own}, {5'h0, resv_owner});
  endtask

  task automatic sense_is(input logic [2:0] iid, input logic [3:0] key);
    cmd(iid, {`SURH_OP_REQSENSE, 24'h0, 8'h03, 8'h00}, `SURH_ST_GOOD);
    chk("sense code", `SURH_SENSE_CODE, u_init.din_q[0]);
    chk("sense key", {4'h0, key}, u_init.din_q[2]);
  endtask

  task automatic t_power_on();
    chk("ua after reset", 8'h01, {7'h0, ua_pending});
    resv_is(1'b0, 3'h0);
    cmd(3'h1, INQ, `SURH_ST_CHECK);
    sense_is(3'h1, `SURH_KEY_UNITATT);
  endtask

  task automatic t_reserve();
    cmd(3'h1, RSV, `SURH_ST_GOOD);
    resv_is(1'b1, 3'h1);
  endtask

  task automatic t_foreign();
    cmd(3'h2, TUR, `SURH_ST_CONFLICT);
    cmd(3'h2, INQ, `SURH_ST_GOOD);
    chk("inquiry count", 8'h04, 8'(u_init.din_q.size()));
    chk("cmd_code", `SURH_OP_INQUIRY, cmd_code);
    for (int i = 0; i < 4; i++) chk("inquiry byte", {1'b1, 7'(i)} ^ 8'h5A, u_init.din_q[i]);
    sense_is(3'h2, `SURH_KEY_NONE);
    cmd(3'h2, REL, `SURH_ST_GOOD);
    resv_is(1'b1, 3'h1);
  endtask

  task automatic t_third_party();
    cmd(3'h1, {`SURH_OP_RESERVE, 8'h0E, 32'h0}, `SURH_ST_GOOD);
    resv_is(1'b1, 3'h1);
    cmd(3'h1, {`SURH_OP_RESERVE, 8'h10, 32'h0}, `SURH_ST_CHECK);
    sense_is(3'h1, `SURH_KEY_ILLEGAL);
    cmd(3'h1, {`SURH_OP_RELEASE, 8'h1E, 32'h0}, `SURH_ST_CHECK);
    resv_is(1'b1, 3'h1);
    cmd(3'h1, {`SURH_OP_INQUIRY, 24'h0, 8'h04, 8'h01}, `SURH_ST_CHECK);
    sense_is(3'h1, `SURH_KEY_ILLEGAL);
  endtask

  task automatic t_release();
    cmd(3'h1, REL, `SURH_ST_GOOD);
    resv_is(1'b0, 3'h0);
    cmd(3'h2, TUR, `SURH_ST_GOOD);
    chk("cmd_strobe count", 8'h01, 8'(strobes));
  endtask

  task automatic t_device_reset();
    cmd(3'h1, RSV, `SURH_ST_GOOD);
    u_init.run(3'h2, `SURH_MSG_BDR, 48'h0);
    chk("no status", 8'hFF, u_init.stat_b);
    resv_is(1'b0, 3'h0);
    chk("ua after message", 8'h01, {7'h0, ua_pending});
    cmd(3'h2, TUR, `SURH_ST_CHECK);
    sense_is(3'h2, `SURH_KEY_UNITATT);
  endtask

  task automatic t_bus_reset();
    cmd(3'h3, RSV, `SURH_ST_GOOD);
    resv_is(1'b1, 3'h3);
    u_init.bus_reset();
    resv_is(1'b0, 3'h0);
    chk("ua after bus reset", 8'h01, {7'h0, ua_pending});
    sense_is(3'h3, `SURH_KEY_UNITATT);
  endtask

  task automatic tally_and_finish();
    $display("counts: compares=%0d fail_count=%0d hangs=%0d", compares, fail_count,
      u_init.hangs);
    if (fail_count == 0 && compares > 0 && u_init.hangs == 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    fail_count = 0;
    compares = 0;
    rstn = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_power_on();
    t_reserve();
    t_foreign();
    t_third_party();
    t_release();
    t_device_reset();
    t_bus_reset();
    tally_and_finish();
  end

  // 21 connections of a few hundred cycles each; generous margin over that
  initial begin
    #600000;
    fail_count++;
    tally_and_finish();
  end
endmodule
